// *** src/duc_defs.svh ***
`ifndef DUC_DEFS_SVH
`define DUC_DEFS_SVH

// ==========================================
// Register byte offsets
`define DUC_ADDR_CTRL   8'h00
`define DUC_ADDR_STATUS 8'h04
`define DUC_ADDR_TXDATA 8'h08
`define DUC_ADDR_RXDATA 8'h0C

// ==========================================
// Reset values
`define DUC_CTRL_RST    12'h000
`define DUC_DATA_RST    8'h00

// ==========================================
// Bit timing in baud clock periods
`define DUC_TICK_LAST   3'h7
`define DUC_TICK_HALF   3'h3

// ==========================================
// Character layout
`define DUC_LAST_BIT8   3'h7
`define DUC_LAST_BIT7   3'h6
`define DUC_MASK8       8'hFF
`define DUC_MASK7_MSB   8'hFE
`define DUC_MASK7_LSB   8'h7F

`endif

// *** src/duc_pkg.sv ***
package duc_pkg;

    // ==========================================
    // Control register layout
    typedef struct packed {
        logic break_tx_enable;
        logic parity_mode_hi;
        logic parity_mode_lo;
        logic parity_disable;
        logic frame_format_hi;
        logic frame_format_lo;
        logic msb_first;
        logic rx_pin_func_en;
        logic tx_pin_func_en;
        logic shared_pin_direction;
        logic input_pin_sel;
        logic comm_type_sel;
    } duc_ctrl_type;

    // ==========================================
    // Status register layout
    typedef struct packed {
        logic break_rx_flag;
        logic any_error_flag;
        logic framing_err_flag;
        logic parity_err_flag;
        logic overrun_err_flag;
        logic rx_full_flag;
        logic rx_busy_flag;
        logic tx_pending_status;
        logic tx_busy_flag;
    } duc_status_type;

    // ==========================================
    // Frame sequencer states
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } duc_tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } duc_rx_state_type;

endpackage

// *** src/duc_uart.sv ***
// How it works
// - Writing transmit buffer starts a frame
// - Start needs low longer than half bit
// - Frame sent raises transmit-done request
// - Bit counter cleared after start detection
// - Frame received raises receive-done request
// - Both directions independent, shared frame format
// - Async mode: length from frame format
// - Format selects 7/8 data, 1/2 stops
// - Input pin select; shared pin direction
// - One start, data, parity, then stops
// - Parity none, fixed 0/1, odd, even
// - Break sends zero in every position
// - Receive buffer loaded, full flag, read clears
// - Receive busy from start to done
// - Transmit busy spans queued frames; pin off clears
// - Summary error flag follows any error
// - Parity/framing flags updated per frame
// - Overrun set on unread buffer, held
// - Parity error for each parity mode
// - Framing error on missing stop bit
// - Software selects MSB or LSB first
// - Queued character follows with no gap
// - 7-bit MSB uses bits 1-7
// - All-zero frame sets break-received flag
// - Bit period is eight baud clocks
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "duc_defs.svh"

module duc_uart import duc_pkg::*; (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Baud timer output
    input  wire logic        baud_clk_in,
    // Serial pins
    output      logic        serial_out_pin_o,
    output      logic        serial_out_pin_oe,
    input  wire logic        serial_out_pin_i,
    input  wire logic        serial_in_pin,
    // Completion requests
    output      logic        tx_done_irq,
    output      logic        rx_done_irq
);

    // ==========================================
    // Helpers
    function automatic logic [2:0] bit_pos(
        input logic [2:0] idx, input logic msb);
        return msb ? 3'h7 - idx : idx;
    endfunction

    function automatic logic par_bit(input logic [7:0] d,
        input logic [7:0] m, input logic [1:0] mode);
        logic p;
        p = ^(d & m);
        case (mode)
            2'b00:   return 1'b0;
            2'b01:   return 1'b1;
            2'b10:   return ~p;
            default: return p;
        endcase
    endfunction

    // ==========================================
    // Configuration
    duc_ctrl_type ctrl_q;
    logic         baud_prev_q;
    wire  logic   tick    = baud_clk_in & ~baud_prev_q;
    wire  logic   uart_on = ctrl_q.comm_type_sel;
    wire  logic   char8   = ctrl_q.frame_format_hi;
    wire  logic   two_stp = ctrl_q.frame_format_lo;
    wire  logic   par_on  = ~ctrl_q.parity_disable;
    wire  logic   msb     = ctrl_q.msb_first;
    wire  logic [1:0] pmode = {ctrl_q.parity_mode_hi,
                               ctrl_q.parity_mode_lo};
    wire  logic [2:0] last_bit = char8 ? `DUC_LAST_BIT8
                                       : `DUC_LAST_BIT7;
    wire  logic [7:0] cmask = char8 ? `DUC_MASK8 :
        (msb ? `DUC_MASK7_MSB : `DUC_MASK7_LSB);

    // ==========================================
    // APB decode
    wire logic acc_p  = psel & penable & ~pready;
    wire logic fire   = psel & penable & pready;
    wire logic a_ctrl = paddr == `DUC_ADDR_CTRL;
    wire logic a_stat = paddr == `DUC_ADDR_STATUS;
    wire logic a_tx   = paddr == `DUC_ADDR_TXDATA;
    wire logic a_rx   = paddr == `DUC_ADDR_RXDATA;
    wire logic mapped = a_ctrl | a_stat | a_tx | a_rx;
    wire logic wr_ctl = fire & pwrite & a_ctrl;
    wire logic wr_tx  = fire & pwrite & a_tx;
    wire logic rd_rx  = fire & ~pwrite & a_rx;

    // ==========================================
    // Transmitter
    duc_tx_state_type tx_st_q, tx_st_d;
    logic [2:0] tx_tk_q, tx_tk_d, tx_idx_q, tx_idx_d;
    logic       tx_stp_q, tx_stp_d, tx_pend_q, tx_pend_d;
    logic       tx_busy_q, tx_busy_d, tx_done_d, tx_val;
    logic [7:0] tx_sh_q, tx_sh_d, tx_hold_q, tx_hold_d;
    wire  logic tx_run  = uart_on & ctrl_q.tx_pin_func_en;
    wire  logic tx_bend = tick & (tx_tk_q == `DUC_TICK_LAST);

    always_comb begin
        tx_st_d   = tx_st_q;
        tx_tk_d   = tick ? tx_tk_q + 3'h1 : tx_tk_q;
        tx_idx_d  = tx_idx_q;
        tx_stp_d  = tx_stp_q;
        tx_pend_d = tx_pend_q;
        tx_busy_d = tx_busy_q;
        tx_sh_d   = tx_sh_q;
        tx_hold_d = tx_hold_q;
        tx_done_d = 1'b0;
        case (tx_st_q)
            TX_IDLE: begin
                tx_tk_d = 3'h0;
                if (tx_pend_q) begin
                    tx_st_d   = TX_START;
                    tx_sh_d   = tx_hold_q;
                    tx_pend_d = 1'b0;
                end
            end
            TX_START: begin
                if (tx_bend) begin
                    tx_st_d  = TX_DATA;
                    tx_idx_d = 3'h0;
                end
            end
            TX_DATA: begin
                if (tx_bend) begin
                    if (tx_idx_q == last_bit) begin
                        tx_st_d  = par_on ? TX_PAR : TX_STOP;
                        tx_stp_d = 1'b0;
                    end else begin
                        tx_idx_d = tx_idx_q + 3'h1;
                    end
                end
            end
            TX_PAR: begin
                if (tx_bend) begin
                    tx_st_d  = TX_STOP;
                    tx_stp_d = 1'b0;
                end
            end
            TX_STOP: begin
                if (tx_bend) begin
                    if (two_stp && !tx_stp_q) begin
                        tx_stp_d = 1'b1;
                    end else begin
                        tx_done_d = 1'b1;
                        if (tx_pend_q) begin
                            tx_st_d   = TX_START;
                            tx_sh_d   = tx_hold_q;
                            tx_pend_d = 1'b0;
                        end else begin
                            tx_st_d   = TX_IDLE;
                            tx_busy_d = 1'b0;
                        end
                    end
                end
            end
            default: tx_st_d = TX_IDLE;
        endcase
        if (wr_tx) begin
            tx_hold_d = pwdata[7:0];
            tx_pend_d = 1'b1;
            tx_busy_d = 1'b1;
        end
        // Pin off aborts the frame and drops anything queued
        if (!tx_run) begin
            tx_st_d   = TX_IDLE;
            tx_pend_d = 1'b0;
            tx_busy_d = 1'b0;
        end
    end

    always_comb begin
        case (tx_st_q)
            TX_START: tx_val = 1'b0;
            TX_DATA:  tx_val = tx_sh_q[bit_pos(tx_idx_q, msb)];
            TX_PAR:   tx_val = par_bit(tx_sh_q, cmask, pmode);
            default:  tx_val = 1'b1;
        endcase
        if (ctrl_q.break_tx_enable && tx_st_q != TX_IDLE) begin
            tx_val = 1'b0;
        end
    end

    // ==========================================
    // Receiver
    duc_rx_state_type rx_st_q, rx_st_d;
    logic [2:0] rx_tk_q, rx_tk_d, rx_idx_q, rx_idx_d;
    logic       rx_stp_q, rx_stp_d, rx_zero_q, rx_zero_d;
    logic       rx_pb_q, rx_pb_d, rx_fe_q, rx_fe_d;
    logic       rx_prev_q, rx_cpl;
    logic [7:0] rx_sh_q, rx_sh_d, rx_buf_q, rx_buf_d;
    logic       full_q, full_d, ovr_q, ovr_d, pe_q, pe_d;
    logic       fe_q, fe_d, brk_q, brk_d, rx_busy_q, rx_busy_d;
    wire  logic rx_in   = ctrl_q.input_pin_sel ? serial_out_pin_i
                                               : serial_in_pin;
    wire  logic rx_run  = uart_on & ctrl_q.rx_pin_func_en;
    wire  logic rx_bend = tick & (rx_tk_q == `DUC_TICK_LAST);
    wire  logic rx_half = tick & (rx_tk_q == `DUC_TICK_HALF);

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_tk_d   = tick ? rx_tk_q + 3'h1 : rx_tk_q;
        rx_idx_d  = rx_idx_q;
        rx_stp_d  = rx_stp_q;
        rx_zero_d = rx_zero_q;
        rx_pb_d   = rx_pb_q;
        rx_fe_d   = rx_fe_q;
        rx_sh_d   = rx_sh_q;
        rx_buf_d  = rx_buf_q;
        full_d    = full_q;
        ovr_d     = ovr_q;
        pe_d      = pe_q;
        fe_d      = fe_q;
        brk_d     = brk_q;
        rx_busy_d = rx_busy_q;
        rx_cpl    = 1'b0;
        // Reading the buffer clears; a completion below wins
        if (rd_rx) begin
            full_d = 1'b0;
            ovr_d  = 1'b0;
        end
        case (rx_st_q)
            RX_IDLE: begin
                rx_tk_d = 3'h0;
                if (rx_prev_q && !rx_in) begin
                    rx_st_d = RX_START;
                end
            end
            RX_START: begin
                if (rx_in) begin
                    rx_st_d = RX_IDLE;
                end else if (rx_half) begin
                    rx_st_d   = RX_DATA;
                    rx_tk_d   = 3'h0;
                    rx_idx_d  = 3'h0;
                    rx_sh_d   = `DUC_DATA_RST;
                    rx_zero_d = 1'b1;
                    rx_fe_d   = 1'b0;
                    rx_busy_d = 1'b1;
                end
            end
            RX_DATA: begin
                if (rx_bend) begin
                    rx_sh_d[bit_pos(rx_idx_q, msb)] = rx_in;
                    rx_zero_d = rx_zero_q & ~rx_in;
                    if (rx_idx_q == last_bit) begin
                        rx_st_d  = par_on ? RX_PAR : RX_STOP;
                        rx_stp_d = 1'b0;
                    end else begin
                        rx_idx_d = rx_idx_q + 3'h1;
                    end
                end
            end
            RX_PAR: begin
                if (rx_bend) begin
                    rx_pb_d   = rx_in;
                    rx_zero_d = rx_zero_q & ~rx_in;
                    rx_st_d   = RX_STOP;
                    rx_stp_d  = 1'b0;
                end
            end
            RX_STOP: begin
                if (rx_bend) begin
                    rx_fe_d   = rx_fe_q | ~rx_in;
                    rx_zero_d = rx_zero_q & ~rx_in;
                    if (two_stp && !rx_stp_q) begin
                        rx_stp_d = 1'b1;
                    end else begin
                        rx_cpl = 1'b1;
                    end
                end
            end
            default: rx_st_d = RX_IDLE;
        endcase
        if (rx_cpl) begin
            rx_st_d   = RX_IDLE;
            rx_buf_d  = rx_sh_q;
            full_d    = 1'b1;
            rx_busy_d = 1'b0;
            if (full_q && !rd_rx) begin
                ovr_d = 1'b1;
            end
            pe_d  = par_on & (rx_pb_q != par_bit(rx_sh_q, cmask, pmode));
            fe_d  = rx_fe_d;
            brk_d = rx_zero_d;
        end
        if (!rx_run) begin
            rx_st_d   = RX_IDLE;
            rx_busy_d = 1'b0;
        end
    end

    // ==========================================
    // Status and read data
    duc_status_type stat;
    logic [31:0]    rd_mux;

    always_comb begin
        stat.break_rx_flag     = brk_q;
        stat.any_error_flag    = ovr_q | pe_q | fe_q;
        stat.framing_err_flag  = fe_q;
        stat.parity_err_flag   = pe_q;
        stat.overrun_err_flag  = ovr_q;
        stat.rx_full_flag      = full_q;
        stat.rx_busy_flag      = rx_busy_q;
        stat.tx_pending_status = tx_pend_q;
        stat.tx_busy_flag      = tx_busy_q;
        rd_mux = 32'h0000_0000;
        if (a_ctrl) rd_mux = {20'h0_0000, ctrl_q};
        if (a_stat) rd_mux = {23'h00_0000, stat};
        if (a_tx)   rd_mux = {24'h00_0000, tx_hold_q};
        if (a_rx)   rd_mux = {24'h00_0000, rx_buf_q};
    end

    // ==========================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= duc_ctrl_type'(`DUC_CTRL_RST);
            baud_prev_q <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            tx_st_q <= TX_IDLE;
            {tx_tk_q, tx_idx_q} <= 6'h00;
            {tx_stp_q, tx_pend_q, tx_busy_q} <= 3'h0;
            tx_sh_q <= `DUC_DATA_RST;
            tx_hold_q <= `DUC_DATA_RST;
            serial_out_pin_o <= 1'b1;
            serial_out_pin_oe <= 1'b0;
            tx_done_irq <= 1'b0;
            rx_st_q <= RX_IDLE;
            {rx_tk_q, rx_idx_q} <= 6'h00;
            {rx_stp_q, rx_zero_q, rx_pb_q, rx_fe_q} <= 4'h0;
            rx_prev_q <= 1'b1;
            rx_sh_q <= `DUC_DATA_RST;
            rx_buf_q <= `DUC_DATA_RST;
            {full_q, ovr_q, pe_q, fe_q, brk_q} <= 5'h00;
            rx_busy_q <= 1'b0;
            rx_done_irq <= 1'b0;
        end else if (pce) begin
            if (wr_ctl) ctrl_q <= duc_ctrl_type'(pwdata[11:0]);
            baud_prev_q <= baud_clk_in;
            pready <= acc_p;
            pslverr <= acc_p & ~mapped;
            prdata <= (acc_p & ~pwrite) ? rd_mux : 32'h0000_0000;
            tx_st_q <= tx_st_d;
            tx_tk_q <= tx_tk_d;
            tx_idx_q <= tx_idx_d;
            tx_stp_q <= tx_stp_d;
            tx_pend_q <= tx_pend_d;
            tx_busy_q <= tx_busy_d;
            tx_sh_q <= tx_sh_d;
            tx_hold_q <= tx_hold_d;
            serial_out_pin_o <= tx_val;
            serial_out_pin_oe <= ctrl_q.tx_pin_func_en &
                (~ctrl_q.input_pin_sel | ctrl_q.shared_pin_direction);
            tx_done_irq <= tx_done_d;
            rx_st_q <= rx_st_d;
            rx_tk_q <= rx_tk_d;
            rx_idx_q <= rx_idx_d;
            rx_stp_q <= rx_stp_d;
            rx_zero_q <= rx_zero_d;
            rx_pb_q <= rx_pb_d;
            rx_fe_q <= rx_fe_d;
            rx_prev_q <= rx_in;
            rx_sh_q <= rx_sh_d;
            {rx_buf_q, full_q, ovr_q} <= {rx_buf_d, full_d, ovr_d};
            {pe_q, fe_q, brk_q} <= {pe_d, fe_d, brk_d};
            rx_busy_q <= rx_busy_d;
            rx_done_irq <= rx_cpl;
        end
    end

    // ==========================================
    // Checks
    AST_TX_START: assert property (@(posedge pclk) disable iff (!presetn)
        pce && wr_tx && tx_run && tx_st_q == TX_IDLE ##1 pce
        |=> tx_st_q == TX_START)
        else $error("write did not start a frame");
    AST_TX_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        tx_done_irq |-> $past(tx_st_q) == TX_STOP)
        else $error("transmit done outside stop bit");
    AST_RX_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done_irq |-> full_q && !rx_busy_q)
        else $error("receive done without full buffer");
    AST_GLITCH: assert property (@(posedge pclk) disable iff (!presetn)
        pce && rx_st_q == RX_START && rx_in |=> !rx_busy_q)
        else $error("short low pulse started reception");
    AST_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
        pce && ctrl_q.break_tx_enable && tx_st_q != TX_IDLE
        |=> !serial_out_pin_o)
        else $error("break frame sent a one");
    AST_ERR_SUM: assert property (@(posedge pclk) disable iff (!presetn)
        pce && acc_p && a_stat && !pwrite && (ovr_q || pe_q || fe_q)
        |=> prdata[7])
        else $error("summary error flag missing");
    AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
        pce && rx_cpl && full_q && !rd_rx
        |=> ovr_q ##1 (ovr_q || $past(rd_rx)))
        else $error("overrun not flagged");
    AST_RX_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        pce && !rx_run |=> !rx_busy_q && rx_st_q == RX_IDLE)
        else $error("receive busy with pin function off");
    AST_TX_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        pce && !tx_run |=> !tx_busy_q && !tx_pend_q)
        else $error("transmit busy with pin function off");
    AST_IDLE_HI: assert property (@(posedge pclk) disable iff (!presetn)
        pce && tx_st_q == TX_IDLE |=> serial_out_pin_o)
        else $error("line not idle high");

endmodule

// *** testbench/duc_remote.sv ***
`timescale 1ns/10ps

// ==========================================
// Remote transceiver on the far end of the serial line
module duc_remote (
    // Bit timing
    input  wire logic        baud_clk_in,
    // Serial line
    input  wire logic        line_in,
    output      logic        line_out,
    // Capture of frames sent by the block
    input  wire logic [4:0]  rx_len,
    output      logic [15:0] rx_frame,
    output      int          rx_count
);
    // Samples mid-bit; bits past the frame length read as idle ones
    initial begin
        rx_count = 0;
        rx_frame = '1;
        forever begin
            @(negedge line_in);
            repeat (4) @(posedge baud_clk_in);
            rx_frame = '1;
            for (int i = 0; i < int'(rx_len); i++) begin
                rx_frame[i] = line_in;
                if (i < int'(rx_len) - 1)
                    repeat (8) @(posedge baud_clk_in);
            end
            rx_count++;
        end
    end

    initial line_out = 1'b1;

    // A legal bit lasts 8 ticks; fewer makes a short glitch
    task automatic send(input logic [15:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            @(posedge baud_clk_in);
            line_out <= f[i];
            repeat (per - 1) @(posedge baud_clk_in);
        end
        @(posedge baud_clk_in);
        line_out <= 1'b1;
    endtask
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`include "duc_defs.svh"

module testbench import duc_pkg::*; ;
    // ==========================================
    // Signals
    logic           pclk, presetn, pce, psel, penable, pwrite;
    logic           baud_clk_in, div_q, pready, pslverr, err;
    logic           tx_o, tx_oe, tx_irq, rx_irq, remote_out;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic [15:0]    rx_frame, f;
    logic [4:0]     exp_len;
    int             rx_count, tx_irqs, rx_irqs, fail_count, comparisons;
    int             n, k, j;
    time            t1;
    duc_ctrl_type   c;
    localparam logic [11:0] BASE = 12'h019;
    // No entry asks for seven bits, two stops and no parity
    localparam logic [11:0] CFG [5] = '{12'h180, 12'h040, 12'h2E0,
                                        12'h420, 12'h680};

    duc_uart u_duc_uart (
        .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .baud_clk_in(baud_clk_in),
        .serial_out_pin_o(tx_o), .serial_out_pin_oe(tx_oe),
        .serial_out_pin_i(tx_oe ? tx_o : remote_out),
        .serial_in_pin(c.input_pin_sel ? 1'b1 : remote_out),
        .tx_done_irq(tx_irq), .rx_done_irq(rx_irq));

    duc_remote u_duc_remote (
        .baud_clk_in(baud_clk_in), .line_in(tx_oe ? tx_o : 1'b1),
        .line_out(remote_out), .rx_len(exp_len), .rx_frame(rx_frame),
        .rx_count(rx_count));

    // ==========================================
    // Clocks; one baud tick every four bus cycles
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        div_q <= ~div_q;
        if (div_q)
            baud_clk_in <= ~baud_clk_in;
        if (tx_irq === 1'b1)
            tx_irqs++;
        if (rx_irq === 1'b1)
            rx_irqs++;
    end

    // ==========================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_for(ref int cnt, input int target);
        for (int w = 0; w < 4000 && cnt < target; w++)
            @(posedge pclk);
        if (cnt < target)
            chk(32'h0, 32'h1);
    endtask

    // Wire order of a frame for the current control word, start first
    function automatic logic [15:0] frame(input logic [7:0] d,
                                          output int len);
        logic [7:0]  ch;
        logic [15:0] fr;
        int          nc;
        nc = c.frame_format_hi ? 8 : 7;
        ch = 8'h00;
        fr = 16'hFFFE;
        for (int i = 0; i < nc; i++) begin
            ch[i]     = c.msb_first ? d[7 - i] : d[i];
            fr[i + 1] = ch[i];
        end
        len = nc + 1;
        if (!c.parity_disable) begin
            fr[len] = c.parity_mode_hi ? ^ch ^ ~c.parity_mode_lo
                                       : c.parity_mode_lo;
            len++;
        end
        len += c.frame_format_lo ? 2 : 1;
        return c.break_tx_enable ? 16'hFFFF << len : fr;
    endfunction

    // Sends and receives one frame at once, then checks both sides
    task automatic duplex(input logic [7:0] dt, input logic [7:0] dr,
                          input logic [31:0] st);
        logic [15:0] ft;
        logic [15:0] fr;
        logic [7:0]  m;
        int          len;
        int          r0;
        int          t0;
        ft = frame(dt, len);
        fr = frame(dr, len);
        exp_len = 5'(len);
        r0 = rx_irqs;
        t0 = tx_irqs;
        m = c.frame_format_hi ? `DUC_MASK8 :
            c.msb_first ? `DUC_MASK7_MSB : `DUC_MASK7_LSB;
        apb(1'b1, `DUC_ADDR_CTRL, 32'(c));
        fork
            u_duc_remote.send(fr, len, 8);
            apb(1'b1, `DUC_ADDR_TXDATA, {24'h0, dt});
        join
        wait_for(rx_irqs, r0 + 1);
        wait_for(tx_irqs, t0 + 1);
        chk(32'(rx_frame), 32'(ft));
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd, st);
        apb(1'b0, `DUC_ADDR_RXDATA, 32'h0);
        chk(rd & 32'(m), 32'(dr & m));
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd, st & 32'h0000_01E0);
    endtask

    // ==========================================
    // Tests
    initial begin
        pclk        = 1'b0;
        div_q       = 1'b0;
        baud_clk_in = 1'b0;
        presetn     = 1'b0;
        pce         = 1'b1;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0000_0000;
        c           = '0;
        exp_len     = 5'd10;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(tx_o), 32'h1);
        apb(1'b0, `DUC_ADDR_CTRL, 32'h0);
        chk(rd, 32'(`DUC_CTRL_RST));
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        for (int i = 0; i < 5; i++) begin
            c = duc_ctrl_type'(BASE | CFG[i]);
            duplex(8'hA5 ^ 8'(i * 37), 8'h3C + 8'(i * 29), 32'h0000_0008);
        end
        c = duc_ctrl_type'(BASE | 12'h980);
        duplex(8'h00, 8'h00, 32'h0000_01C8);
        // Second write lands while the first frame is on the line
        c = duc_ctrl_type'(BASE | 12'h180);
        k = tx_irqs;
        apb(1'b1, `DUC_ADDR_CTRL, 32'(c));
        apb(1'b1, `DUC_ADDR_TXDATA, 32'h0000_0011);
        apb(1'b1, `DUC_ADDR_TXDATA, 32'h0000_0022);
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd & 32'h0000_0003, 32'h0000_0003);
        j = rx_count;
        wait_for(rx_count, j + 1);
        chk(32'(rx_frame), 32'(frame(8'h11, n)));
        wait_for(tx_irqs, k + 1);
        t1 = $time;
        wait_for(rx_count, j + 2);
        chk(32'(rx_frame), 32'(frame(8'h22, n)));
        wait_for(tx_irqs, k + 2);
        chk(32'(($time - t1) / 25), 32'd320);
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_01C0);
        // Wrong parity bit under every parity mode
        for (int p = 0; p < 4; p++) begin
            c = duc_ctrl_type'(BASE | 12'h080 | 12'(p << 9));
            apb(1'b1, `DUC_ADDR_CTRL, 32'(c));
            f = frame(8'h5A, n);
            k = rx_irqs;
            u_duc_remote.send(f ^ 16'h0200, n, 8);
            wait_for(rx_irqs, k + 1);
            apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
            chk(rd, 32'h0000_00A8);
            apb(1'b0, `DUC_ADDR_RXDATA, 32'h0);
        end
        // Good frame, then a missing stop bit while still unread
        k = rx_irqs;
        u_duc_remote.send(f, n, 8);
        u_duc_remote.send(f & 16'hFBFF, n, 8);
        wait_for(rx_irqs, k + 2);
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_00D8);
        apb(1'b0, `DUC_ADDR_RXDATA, 32'h0);
        chk(rd & 32'h0000_00FF, 32'h0000_005A);
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_00C0);
        // Low pulse of a quarter bit must not start reception
        k = rx_irqs;
        u_duc_remote.send(16'h0000, 1, 2);
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd & 32'h0000_0004, 32'h0);
        repeat (400) @(posedge pclk);
        chk(32'(rx_irqs), 32'(k));
        // One-pin mode: receive through the shared output pin
        c = duc_ctrl_type'(BASE | 12'h182);
        apb(1'b1, `DUC_ADDR_CTRL, 32'(c));
        f = frame(8'hC3, n);
        k = rx_irqs;
        fork
            u_duc_remote.send(f, n, 8);
            begin
                repeat (120) @(posedge pclk);
                apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
                chk(rd & 32'h0000_0004, 32'h0000_0004);
                chk(32'(tx_oe), 32'h0);
            end
        join
        wait_for(rx_irqs, k + 1);
        apb(1'b0, `DUC_ADDR_RXDATA, 32'h0);
        chk(rd & 32'h0000_00FF, 32'h0000_00C3);
        // Pin functions switched off in mid-frame
        c = duc_ctrl_type'(BASE | 12'h180);
        apb(1'b1, `DUC_ADDR_CTRL, 32'(c));
        f = frame(8'h66, n);
        apb(1'b1, `DUC_ADDR_TXDATA, 32'h0000_0099);
        fork
            u_duc_remote.send(f, n, 8);
        join_none
        repeat (100) @(posedge pclk);
        apb(1'b1, `DUC_ADDR_CTRL, 32'h0000_0181);
        apb(1'b0, `DUC_ADDR_STATUS, 32'h0);
        chk(rd & 32'h0000_0007, 32'h0);
        end_of_test;
    end

    initial begin
        #1_000_000;
        chk(32'h0, 32'h1);
        end_of_test;
    end
endmodule
